// ### rtl/rtx_defines.svh
// Opcodes, masks, reset values and timing for the register transfer executor.
`ifndef RTX_DEFINES_SVH
`define RTX_DEFINES_SVH
`define OPC_COPY_B_INTO_ACC 10'h01E
`define OPC_COPY_ACC_INTO_B 10'h00E
`define OPC_READ_ROW_POINTER 10'h01F
`define OPC_WRITE_ROW_POINTER 10'h00C
`define OPC_LOAD_WIDE_PAIR 10'h01A
`define OPC_LOAD_PAGE_REG 10'h029
`define OPC_READ_PAGE_REG 10'h051
`define OPC_READ_FILE_REG 10'h053
`define OPC_READ_COLUMN_REG 10'h052
`define OPC_READ_STACK_POINTER 10'h050
`define OPC_ROW_INCREMENT 10'h013
`define OPC_ROW_DECREMENT 10'h017
`define OPC_WATCHDOG_TEST_CLEAR 10'h2A0
`define OPC_WRITE_IRQ_CTRL_FIRST 10'h03F
`define OPC_WRITE_IRQ_CTRL_SECOND 10'h03E
`define OPC_WRITE_TIMER_CTRL_FIRST 10'h20E
`define OPC_WRITE_TIMER_CTRL_SECOND 10'h20F
`define OPC_WRITE_TIMER_CTRL_THIRD 10'h210
`define OPC_WRITE_TIMER_CTRL_FOURTH 10'h211
`define MASK_LOAD_XY 10'h300
`define OPC_LOAD_XY 10'h300
`define MASK_LOAD_Z 10'h3FC
`define OPC_LOAD_FILE_IMM 10'h048
`define MASK_IMM4 10'h3F0
`define OPC_RAM_TO_ACC 10'h2C0
`define OPC_SWAP_ACC_RAM 10'h2D0
`define OPC_SWAP_AND_ROW_DOWN 10'h2F0
`define OPC_SWAP_AND_ROW_UP 10'h2E0
`define OPC_ACC_TO_RAM 10'h2B0
`define RESET_NIBBLE 4'h0
`define RESET_WIDE 8'h00
`define RESET_PAGE 3'h0
`define RESET_FILE 2'h0
`define ROW_TOP 4'hF
`define ROW_BOTTOM 4'h0
`define INSTR_CYCLES 1
`endif

// ### rtl/rtx_pkg.sv
// Types shared by the register transfer executor and its users.
package rtx_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_COPY_B_INTO_ACC, OP_COPY_ACC_INTO_B, OP_READ_ROW, OP_WRITE_ROW,
    OP_LOAD_WIDE, OP_LOAD_PAGE, OP_READ_PAGE, OP_READ_FILE, OP_READ_COLUMN,
    OP_READ_SP, OP_LOAD_XY, OP_LOAD_Z, OP_ROW_INC, OP_ROW_DEC, OP_RAM_TO_ACC,
    OP_SWAP, OP_SWAP_DOWN, OP_SWAP_UP, OP_ACC_TO_RAM, OP_WDOG,
    OP_IRQ1, OP_IRQ2, OP_TMR1, OP_TMR2, OP_TMR3, OP_TMR4
  } op_t;
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] y;
    logic [1:0] z;
    logic [7:0] e;
    logic [2:0] d;
  } core_t;
  typedef struct packed {
    logic [3:0] irq1;
    logic [3:0] irq2;
    logic [3:0] tmr1;
    logic [3:0] tmr2;
    logic [3:0] tmr3;
    logic [3:0] tmr4;
  } ctrl_t;
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } ram_wr_t;
endpackage

// ### rtl/register_transfer_instr_exec.sv
// Executes the register and RAM transfer instructions of the 4-bit core.
`timescale 1ns/1ps
`include "rtx_defines.svh"

// Function
// - Copy-B instruction loads all four bits of B into the accumulator.
// - Read-row instruction places pointer Y into the accumulator in one cycle.
// - Write-row instruction loads Y from the accumulator, no skip.
// - Load-wide instruction puts B in E high nibble, accumulator in low nibble.
// - Load-page instruction copies accumulator bits 2..0 into D, bit 3 dropped.
// - Read-page instruction puts D in accumulator bits 2..0, bit 3 cleared.
// - Read-file instruction puts Z in accumulator bits 1..0, upper bits cleared.
// - Read-column instruction copies all of X into the accumulator.
// - Read-stack instruction puts stack pointer in bits 2..0, bit 3 cleared.
// - Load-XY immediate takes X from opcode bits 7..4, Y from 3..0.
// - Load-Z immediate takes Z from the two low opcode bits.
// - Row increment adds one to Y modulo sixteen.
// - Row decrement subtracts one from Y modulo sixteen.
// - RAM-to-accumulator loads the addressed nibble and XORs X with immediate.
// - Swap exchanges accumulator and addressed nibble, XORs X with immediate.
// - Swap-down also decrements Y and skips next when Y becomes fifteen.
// - Swap-up also increments Y and skips next when Y wraps to zero.
// - Accumulator-to-RAM writes the nibble and XORs X with immediate.
// - Watchdog test skips and clears the first watchdog flag when it is set.
// - Each interrupt-control write copies the accumulator into its own register.
// - Each timer-control write copies the accumulator into its own register.
module register_transfer_instr_exec (
  input wire logic clock, // 100 MHz instruction clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic clock_enable, // Freezes all state while low
  input wire logic instr_valid, // Opcode presented this cycle
  input wire logic [9:0] opcode, // Instruction word
  input wire logic [3:0] ram_rd_data, // Nibble at the data pointer
  input wire logic [2:0] stack_ptr, // Current stack pointer
  input wire logic wdog_flag_set, // Watchdog timer sets the first flag
  output rtx_pkg::core_t core, // Core registers
  output rtx_pkg::ctrl_t ctrl, // Interrupt and timer control registers
  output rtx_pkg::ram_wr_t ram_wr, // Write to the nibble at the data pointer
  output logic skip_active, // Next instruction will be discarded
  output logic watchdog_flag_first // First watchdog flag
);
  import rtx_pkg::*;

  core_t next_core;
  ctrl_t next_ctrl;
  ram_wr_t next_ram_wr;
  logic next_skip;
  logic next_wdf;
  logic xy_chain;
  logic next_xy_chain;
  op_t op;
  logic go;
  logic [3:0] imm;

  function automatic op_t decode(input logic [9:0] w);
    op_t r;
    r = OP_NONE;
    if ((w & `MASK_LOAD_XY) == `OPC_LOAD_XY) r = OP_LOAD_XY;
    else if ((w & `MASK_LOAD_Z) == `OPC_LOAD_FILE_IMM) r = OP_LOAD_Z;
    else if ((w & `MASK_IMM4) == `OPC_RAM_TO_ACC) r = OP_RAM_TO_ACC;
    else if ((w & `MASK_IMM4) == `OPC_SWAP_ACC_RAM) r = OP_SWAP;
    else if ((w & `MASK_IMM4) == `OPC_SWAP_AND_ROW_DOWN) r = OP_SWAP_DOWN;
    else if ((w & `MASK_IMM4) == `OPC_SWAP_AND_ROW_UP) r = OP_SWAP_UP;
    else if ((w & `MASK_IMM4) == `OPC_ACC_TO_RAM) r = OP_ACC_TO_RAM;
    else begin
      case (w)
        `OPC_COPY_B_INTO_ACC: r = OP_COPY_B_INTO_ACC;
        `OPC_COPY_ACC_INTO_B: r = OP_COPY_ACC_INTO_B;
        `OPC_READ_ROW_POINTER: r = OP_READ_ROW;
        `OPC_WRITE_ROW_POINTER: r = OP_WRITE_ROW;
        `OPC_LOAD_WIDE_PAIR: r = OP_LOAD_WIDE;
        `OPC_LOAD_PAGE_REG: r = OP_LOAD_PAGE;
        `OPC_READ_PAGE_REG: r = OP_READ_PAGE;
        `OPC_READ_FILE_REG: r = OP_READ_FILE;
        `OPC_READ_COLUMN_REG: r = OP_READ_COLUMN;
        `OPC_READ_STACK_POINTER: r = OP_READ_SP;
        `OPC_ROW_INCREMENT: r = OP_ROW_INC;
        `OPC_ROW_DECREMENT: r = OP_ROW_DEC;
        `OPC_WATCHDOG_TEST_CLEAR: r = OP_WDOG;
        `OPC_WRITE_IRQ_CTRL_FIRST: r = OP_IRQ1;
        `OPC_WRITE_IRQ_CTRL_SECOND: r = OP_IRQ2;
        `OPC_WRITE_TIMER_CTRL_FIRST: r = OP_TMR1;
        `OPC_WRITE_TIMER_CTRL_SECOND: r = OP_TMR2;
        `OPC_WRITE_TIMER_CTRL_THIRD: r = OP_TMR3;
        `OPC_WRITE_TIMER_CTRL_FOURTH: r = OP_TMR4;
        default: r = OP_NONE;
      endcase
    end
    return r;
  endfunction

  assign op = decode(opcode);
  assign imm = opcode[3:0];
  // Reset wins over execution, so a cycle held in reset never counts as an executed instruction.
  assign go = clock_enable && instr_valid && !skip_active && !srst;

  always_comb begin
    next_core = core;
    next_ctrl = ctrl;
    // The RAM strobe leaves a flop one cycle late, so an instruction that reads the same
    // nibble right after a write sees the old data unless the RAM bypasses it.
    next_ram_wr = '0;
    next_skip = skip_active;
    next_xy_chain = xy_chain;
    next_wdf = watchdog_flag_first;
    if (instr_valid) begin
      next_skip = 1'b0;
      next_xy_chain = 1'b0;
    end
    if (go) begin
      next_xy_chain = (op == OP_LOAD_XY);
      case (op)
        OP_COPY_B_INTO_ACC: next_core.acc = core.b;
        OP_COPY_ACC_INTO_B: next_core.b = core.acc;
        OP_READ_ROW: next_core.acc = core.y;
        OP_WRITE_ROW: next_core.y = core.acc;
        OP_LOAD_WIDE: next_core.e = {core.b, core.acc};
        OP_LOAD_PAGE: next_core.d = core.acc[2:0];
        OP_READ_PAGE: next_core.acc = {1'b0, core.d};
        OP_READ_FILE: next_core.acc = {2'b00, core.z};
        OP_READ_COLUMN: next_core.acc = core.x;
        OP_READ_SP: next_core.acc = {1'b0, stack_ptr};
        OP_LOAD_XY: begin
          // Only the first of a run of back-to-back loads takes effect.
          if (!xy_chain) begin
            next_core.x = opcode[7:4];
            next_core.y = opcode[3:0];
          end
        end
        OP_LOAD_Z: next_core.z = opcode[1:0];
        OP_ROW_INC: begin
          next_core.y = 4'(core.y + 4'h1);
          next_skip = (4'(core.y + 4'h1) == `ROW_BOTTOM);
        end
        OP_ROW_DEC: begin
          next_core.y = 4'(core.y - 4'h1);
          next_skip = (4'(core.y - 4'h1) == `ROW_TOP);
        end
        OP_RAM_TO_ACC: begin
          next_core.acc = ram_rd_data;
          next_core.x = core.x ^ imm;
        end
        OP_SWAP, OP_SWAP_DOWN, OP_SWAP_UP: begin
          next_core.acc = ram_rd_data;
          next_ram_wr = '{en: 1'b1, data: core.acc};
          next_core.x = core.x ^ imm;
          if (op == OP_SWAP_DOWN) begin
            next_core.y = 4'(core.y - 4'h1);
            next_skip = (4'(core.y - 4'h1) == `ROW_TOP);
          end
          if (op == OP_SWAP_UP) begin
            next_core.y = 4'(core.y + 4'h1);
            next_skip = (4'(core.y + 4'h1) == `ROW_BOTTOM);
          end
        end
        OP_ACC_TO_RAM: begin
          next_ram_wr = '{en: 1'b1, data: core.acc};
          next_core.x = core.x ^ imm;
        end
        OP_WDOG: begin
          if (watchdog_flag_first) begin
            next_skip = 1'b1;
            next_wdf = 1'b0;
          end
        end
        OP_IRQ1: next_ctrl.irq1 = core.acc;
        OP_IRQ2: next_ctrl.irq2 = core.acc;
        OP_TMR1: next_ctrl.tmr1 = core.acc;
        OP_TMR2: next_ctrl.tmr2 = core.acc;
        OP_TMR3: next_ctrl.tmr3 = core.acc;
        OP_TMR4: next_ctrl.tmr4 = core.acc;
        default: next_core = core;
      endcase
    end
    // A set from the watchdog timer wins over a clear in the same cycle.
    if (wdog_flag_set) next_wdf = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      core <= '{acc: `RESET_NIBBLE, b: `RESET_NIBBLE, x: `RESET_NIBBLE,
                y: `RESET_NIBBLE, z: `RESET_FILE, e: `RESET_WIDE, d: `RESET_PAGE};
      ctrl <= '{`RESET_NIBBLE, `RESET_NIBBLE, `RESET_NIBBLE,
                `RESET_NIBBLE, `RESET_NIBBLE, `RESET_NIBBLE};
      ram_wr <= '0;
      skip_active <= 1'b0;
      xy_chain <= 1'b0;
      watchdog_flag_first <= 1'b0;
    end else if (clock_enable) begin
      core <= next_core;
      ctrl <= next_ctrl;
      ram_wr <= next_ram_wr;
      skip_active <= next_skip;
      xy_chain <= next_xy_chain;
      watchdog_flag_first <= next_wdf;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_swap_down;
    go && op == OP_SWAP_DOWN;
  endsequence
  sequence s_swap_up;
    go && op == OP_SWAP_UP;
  endsequence

  copy_b_acc_a: assert property (go && op == OP_COPY_B_INTO_ACC |=>
    core.acc == $past(core.b) && core.b == $past(core.b))
    else $error("accumulator did not take B");
  copy_acc_b_a: assert property (go && op == OP_COPY_ACC_INTO_B |=>
    core.b == $past(core.acc)) else $error("B did not take accumulator");
  wide_pair_a: assert property (go && op == OP_LOAD_WIDE |=>
    core.e == {$past(core.b), $past(core.acc)}) else $error("E load wrong");
  read_page_a: assert property (go && op == OP_READ_PAGE |=>
    core.acc[3] == 1'b0 && core.acc[2:0] == $past(core.d))
    else $error("page read wrong");
  load_xy_a: assert property (go && op == OP_LOAD_XY && !xy_chain |=>
    core.x == $past(opcode[7:4]) && core.y == $past(opcode[3:0]))
    else $error("XY immediate load wrong");
  row_wrap_a: assert property (go && op == OP_ROW_INC && core.y == 4'hF |=>
    core.y == 4'h0 && skip_active) else $error("row increment wrap wrong");
  ram_acc_a: assert property (go && op == OP_RAM_TO_ACC |=>
    core.acc == $past(ram_rd_data) && core.x == ($past(core.x) ^ $past(imm))
    && !ram_wr.en) else $error("RAM load wrong");
  swap_down_a: assert property (s_swap_down |=>
    core.y == 4'($past(core.y) - 4'h1) && skip_active == (core.y == 4'hF)
    && ram_wr.en && ram_wr.data == $past(core.acc)) else $error("swap down wrong");
  swap_up_a: assert property (s_swap_up |=>
    core.y == 4'($past(core.y) + 4'h1) && skip_active == (core.y == 4'h0))
    else $error("swap up wrong");
  wdog_clear_a: assert property (go && op == OP_WDOG && watchdog_flag_first
    && !wdog_flag_set |=> skip_active && !watchdog_flag_first)
    else $error("watchdog test did not skip and clear");
  timer_ctrl_a: assert property (go && op == OP_TMR3 |=>
    ctrl.tmr3 == $past(core.acc) && ctrl.tmr1 == $past(ctrl.tmr1))
    else $error("timer control write wrong");
  skip_drop_a: assert property (!srst && clock_enable && instr_valid && skip_active
    |=> core == $past(core) && !skip_active) else $error("skipped instruction acted");

  // Plain register moves finish in one cycle and the next instruction sees the result.
  read_row_a: assert property (go && op == OP_READ_ROW |=>
    core.acc == $past(core.y) && core.y == $past(core.y))
    else $error("accumulator did not take Y");
  write_row_a: assert property (go && op == OP_WRITE_ROW |=>
    core.y == $past(core.acc) && !skip_active)
    else $error("Y did not take accumulator");
  load_page_a: assert property (go && op == OP_LOAD_PAGE |=>
    core.d == $past(core.acc[2:0]))
    else $error("page register load wrong");
  read_file_a: assert property (go && op == OP_READ_FILE |=>
    core.acc == {2'b00, $past(core.z)})
    else $error("file register read wrong");
  read_column_a: assert property (go && op == OP_READ_COLUMN |=>
    core.acc == $past(core.x))
    else $error("column register read wrong");
  read_stack_a: assert property (go && op == OP_READ_SP |=>
    core.acc == {1'b0, $past(stack_ptr)})
    else $error("stack pointer read wrong");

  // A load that directly follows an executed load is dropped, not merged.
  xy_refuse_a: assert property (go && op == OP_LOAD_XY && xy_chain |=>
    core.x == $past(core.x) && core.y == $past(core.y))
    else $error("chained XY immediate load acted");
  load_file_a: assert property (go && op == OP_LOAD_Z |=>
    core.z == $past(opcode[1:0]))
    else $error("Z immediate load wrong");
  row_down_a: assert property (go && op == OP_ROW_DEC |=>
    core.y == 4'($past(core.y) - 4'h1) && skip_active == (core.y == 4'hF))
    else $error("row decrement wrong");

  // The plain swap moves the old accumulator out and the addressed nibble in; accumulator-to-RAM only moves the accumulator out.
  sequence s_ram_swapped;
    ram_wr.en && ram_wr.data == $past(core.acc) && core.acc == $past(ram_rd_data);
  endsequence
  swap_plain_a: assert property (go && op == OP_SWAP |=>
    s_ram_swapped ##0 core.x == ($past(core.x) ^ $past(imm)))
    else $error("swap wrong");
  acc_ram_a: assert property (go && op == OP_ACC_TO_RAM |=>
    ram_wr.en && ram_wr.data == $past(core.acc) && core.acc == $past(core.acc)
    && core.x == ($past(core.x) ^ $past(imm)))
    else $error("accumulator to RAM wrong");

  wdog_keep_a: assert property (go && op == OP_WDOG && !watchdog_flag_first |=>
    !skip_active)
    else $error("watchdog test skipped with clear flag");
  wdog_set_a: assert property (go && op == OP_WDOG && watchdog_flag_first
    && wdog_flag_set |=> skip_active && watchdog_flag_first)
    else $error("watchdog set lost to clear");
  irq_first_a: assert property (go && op == OP_IRQ1 |=>
    ctrl.irq1 == $past(core.acc) && ctrl.irq2 == $past(ctrl.irq2) && !skip_active)
    else $error("first interrupt control write wrong");
  irq_second_a: assert property (go && op == OP_IRQ2 |=>
    ctrl.irq2 == $past(core.acc) && ctrl.irq1 == $past(ctrl.irq1))
    else $error("second interrupt control write wrong");
  timer_last_a: assert property (go && op == OP_TMR4 |=>
    ctrl.tmr4 == $past(core.acc) && ctrl.tmr3 == $past(ctrl.tmr3))
    else $error("fourth timer control write wrong");

  // A stalled cycle must leave the core and control registers and the RAM strobe alone.
  freeze_hold_a: assert property (!clock_enable && !srst |=>
    core == $past(core) && ctrl == $past(ctrl) && ram_wr == $past(ram_wr))
    else $error("state moved while clock enable was low");
endmodule // register_transfer_instr_exec

// ### bench/test_register_transfer_instr_exec.sv
// Self-checking bench for the register transfer executor, built around a reference model.
`timescale 1ns/1ps
`include "rtx_defines.svh"
module test_register_transfer_instr_exec;
  import rtx_pkg::*;
  typedef struct packed {
    core_t core;
    ctrl_t ctrl;
    ram_wr_t wr;
    logic skip;
    logic wdf;
  } exp_t;
  typedef struct {
    exp_t e;
    int due;
  } note_t;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clock_enable = 1'b1;
  logic instr_valid = 1'b0;
  logic [9:0] opcode = 10'h000;
  logic [3:0] ram_rd_data = 4'h0;
  logic [2:0] stack_ptr = 3'h0;
  logic wdog_flag_set = 1'b0;
  core_t core;
  ctrl_t ctrl;
  ram_wr_t ram_wr;
  logic skip_active;
  logic watchdog_flag_first;
  exp_t m = '0;
  logic chain = 1'b0;
  note_t q[$];
  int cyc = 0;
  int n_fail = 0;
  int checks_done = 0;
  integer seed = 32'h93E5583A;
  logic [9:0] codes [26] = '{`OPC_COPY_B_INTO_ACC, `OPC_COPY_ACC_INTO_B, `OPC_READ_ROW_POINTER,
    `OPC_WRITE_ROW_POINTER, `OPC_LOAD_WIDE_PAIR, `OPC_LOAD_PAGE_REG, `OPC_READ_PAGE_REG,
    `OPC_READ_FILE_REG, `OPC_READ_COLUMN_REG, `OPC_READ_STACK_POINTER, `OPC_ROW_INCREMENT,
    `OPC_ROW_DECREMENT, `OPC_WATCHDOG_TEST_CLEAR, `OPC_WRITE_IRQ_CTRL_FIRST,
    `OPC_WRITE_IRQ_CTRL_SECOND, `OPC_WRITE_TIMER_CTRL_FIRST, `OPC_WRITE_TIMER_CTRL_SECOND,
    `OPC_WRITE_TIMER_CTRL_THIRD, `OPC_WRITE_TIMER_CTRL_FOURTH, `OPC_LOAD_XY,
    `OPC_LOAD_FILE_IMM, `OPC_RAM_TO_ACC, `OPC_SWAP_ACC_RAM, `OPC_SWAP_AND_ROW_DOWN,
    `OPC_SWAP_AND_ROW_UP, `OPC_ACC_TO_RAM};

  register_transfer_instr_exec u_dut (
    .clock(clock),
    .srst(srst),
    .clock_enable(clock_enable),
    .instr_valid(instr_valid),
    .opcode(opcode),
    .ram_rd_data(ram_rd_data),
    .stack_ptr(stack_ptr),
    .wdog_flag_set(wdog_flag_set),
    .core(core),
    .ctrl(ctrl),
    .ram_wr(ram_wr),
    .skip_active(skip_active),
    .watchdog_flag_first(watchdog_flag_first)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  function automatic logic [9:0] pick(input int k);
    logic [9:0] r;
    r = 10'($random(seed));
    return codes[k] | (k < 19 ? 10'h000 : k == 19 ? r & 10'h0FF : k == 20 ? r & 10'h003 : r & 10'h00F);
  endfunction

  // Mirrors one clock edge of the executor; the result is what the outputs show after it.
  task automatic model(input logic rs, ce, v, input logic [9:0] op, input logic [3:0] r,
                       input logic [2:0] sp, input logic ws);
    logic [3:0] a;
    a = m.core.acc;
    if (rs) begin
      m = '0;
      chain = 1'b0;
    end else if (ce) begin
      m.wr.en = 1'b0;
      if (v && m.skip) begin
        m.skip = 1'b0;
        chain = 1'b0;
      end else if (v && (op & `MASK_LOAD_XY) == `OPC_LOAD_XY) begin
        if (!chain) {m.core.x, m.core.y} = op[7:0];
        chain = 1'b1;
      end else if (v) begin
        chain = 1'b0;
        case (op)
          `OPC_COPY_B_INTO_ACC: m.core.acc = m.core.b;
          `OPC_COPY_ACC_INTO_B: m.core.b = a;
          `OPC_READ_ROW_POINTER: m.core.acc = m.core.y;
          `OPC_WRITE_ROW_POINTER: m.core.y = a;
          `OPC_LOAD_WIDE_PAIR: m.core.e = {m.core.b, a};
          `OPC_LOAD_PAGE_REG: m.core.d = a[2:0];
          `OPC_READ_PAGE_REG: m.core.acc = {1'b0, m.core.d};
          `OPC_READ_FILE_REG: m.core.acc = {2'b00, m.core.z};
          `OPC_READ_COLUMN_REG: m.core.acc = m.core.x;
          `OPC_READ_STACK_POINTER: m.core.acc = {1'b0, sp};
          `OPC_ROW_INCREMENT: m.core.y = m.core.y + 4'h1;
          `OPC_ROW_DECREMENT: m.core.y = m.core.y - 4'h1;
          `OPC_WATCHDOG_TEST_CLEAR: m.skip = m.wdf;
          `OPC_WRITE_IRQ_CTRL_FIRST: m.ctrl.irq1 = a;
          `OPC_WRITE_IRQ_CTRL_SECOND: m.ctrl.irq2 = a;
          `OPC_WRITE_TIMER_CTRL_FIRST: m.ctrl.tmr1 = a;
          `OPC_WRITE_TIMER_CTRL_SECOND: m.ctrl.tmr2 = a;
          `OPC_WRITE_TIMER_CTRL_THIRD: m.ctrl.tmr3 = a;
          `OPC_WRITE_TIMER_CTRL_FOURTH: m.ctrl.tmr4 = a;
          default: ;
        endcase
        if (op == `OPC_WATCHDOG_TEST_CLEAR) m.wdf = 1'b0;
        if (op == `OPC_ROW_INCREMENT) m.skip = (m.core.y == `ROW_BOTTOM);
        if (op == `OPC_ROW_DECREMENT) m.skip = (m.core.y == `ROW_TOP);
        if ((op & `MASK_LOAD_Z) == `OPC_LOAD_FILE_IMM) m.core.z = op[1:0];
        case (op & `MASK_IMM4)
          `OPC_RAM_TO_ACC: m.core.acc = r;
          `OPC_ACC_TO_RAM: m.wr = '{1'b1, a};
          `OPC_SWAP_ACC_RAM, `OPC_SWAP_AND_ROW_DOWN, `OPC_SWAP_AND_ROW_UP: begin
            m.core.acc = r;
            m.wr = '{1'b1, a};
          end
          default: ;
        endcase
        if ((op & `MASK_IMM4) == `OPC_SWAP_AND_ROW_DOWN) begin
          m.core.y = m.core.y - 4'h1;
          m.skip = (m.core.y == `ROW_TOP);
        end
        if ((op & `MASK_IMM4) == `OPC_SWAP_AND_ROW_UP) begin
          m.core.y = m.core.y + 4'h1;
          m.skip = (m.core.y == `ROW_BOTTOM);
        end
        if ((op & `MASK_IMM4) inside {`OPC_RAM_TO_ACC, `OPC_ACC_TO_RAM, `OPC_SWAP_ACC_RAM,
            `OPC_SWAP_AND_ROW_DOWN, `OPC_SWAP_AND_ROW_UP}) m.core.x = m.core.x ^ op[3:0];
      end
      // A set request from the watchdog timer wins over the clear of the test instruction.
      if (ws) m.wdf = 1'b1;
    end
  endtask

  task automatic step(input logic rs, ce, v, input logic [9:0] op, input logic ws);
    logic [3:0] r;
    logic [2:0] sp;
    note_t n;
    r = 4'($random(seed));
    sp = 3'($random(seed));
    @(posedge clock);
    srst <= rs;
    clock_enable <= ce;
    instr_valid <= v;
    opcode <= op;
    ram_rd_data <= r;
    stack_ptr <= sp;
    wdog_flag_set <= ws;
    model(rs, ce, v, op, r, sp, ws);
    n.e = m;
    n.due = cyc + 2;
    q.push_back(n);
  endtask

  task automatic run(input logic [9:0] op, input logic ws);
    step(1'b0, 1'b1, 1'b1, op, ws);
  endtask

  task automatic note_bad(input string what, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_core(input core_t e, input core_t g);
    note_bad("core", 64'(e), 64'(g));
  endtask

  task automatic cmp_ctrl(input ctrl_t e, input ctrl_t g);
    note_bad("ctrl", 64'(e), 64'(g));
  endtask

  task automatic cmp_wr(input ram_wr_t e, input ram_wr_t g);
    note_bad("ram_wr", 64'(e.en ? e : {1'b0, g.data}), 64'(g));
  endtask

  task automatic cmp_flags(input logic [1:0] e, input logic [1:0] g);
    note_bad("skip_and_flag", 64'(e), 64'(g));
  endtask

  always @(negedge clock) begin
    cyc = cyc + 1;
    if (q.size() > 0 && q[0].due == cyc) begin
      cmp_core(q[0].e.core, core);
      cmp_ctrl(q[0].e.ctrl, ctrl);
      cmp_wr(q[0].e.wr, ram_wr);
      cmp_flags({q[0].e.skip, q[0].e.wdf}, {skip_active, watchdog_flag_first});
      void'(q.pop_front());
    end
  end

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (4) step(1'b1, 1'b1, 1'b0, 10'h000, 1'b0);
    repeat (2) for (int k = 0; k < 26; k++) run(pick(k), 1'b0);
    run(10'h1FF, 1'b0);
    run(10'h3AF, 1'b0);
    run(10'h35A, 1'b0);
    run(`OPC_SWAP_AND_ROW_UP | 10'h005, 1'b0);
    run(`OPC_COPY_ACC_INTO_B, 1'b0);
    run(`OPC_SWAP_AND_ROW_DOWN | 10'h00C, 1'b0);
    step(1'b0, 1'b1, 1'b0, `OPC_READ_ROW_POINTER, 1'b0);
    step(1'b0, 1'b0, 1'b1, `OPC_READ_ROW_POINTER, 1'b1);
    run(`OPC_ROW_INCREMENT, 1'b0);
    run(`OPC_ROW_INCREMENT, 1'b0);
    run(`OPC_ROW_DECREMENT, 1'b0);
    run(`OPC_ROW_DECREMENT, 1'b0);
    run(`OPC_READ_ROW_POINTER, 1'b0);
    run(`OPC_WATCHDOG_TEST_CLEAR, 1'b1);
    run(`OPC_WATCHDOG_TEST_CLEAR, 1'b1);
    run(`OPC_COPY_ACC_INTO_B, 1'b0);
    run(`OPC_WATCHDOG_TEST_CLEAR, 1'b0);
    run(`OPC_READ_ROW_POINTER, 1'b0);
    run(`OPC_WATCHDOG_TEST_CLEAR, 1'b0);
    for (int i = 0; i < 600; i++) begin
      int k;
      k = ($random(seed) & 32'h7FFF) % 26;
      if (chain && k == 19) k = 0;
      step(i == 300, ($random(seed) & 7) != 0, ($random(seed) & 3) != 0, pick(k),
           ($random(seed) & 7) == 0);
    end
    repeat (3) step(1'b0, 1'b1, 1'b0, 10'h000, 1'b0);
    repeat (3) @(negedge clock);
    give_verdict();
  end
endmodule // test_register_transfer_instr_exec
